// ### rtl/i2csp_consts.svh
// Constants for the two-wire register port
// Assumes inclusion by the package, the register store and the port module only
`ifndef I2CSP_CONSTS_SVH
`define I2CSP_CONSTS_SVH
`define I2CSP_ADDR_HI      6'h17
`define I2CSP_BIT_LAST     3'h7
`define I2CSP_BIT_FIRST    3'h0
`define I2CSP_PTR_RESET    8'h00
`define I2CSP_PROG_BIT     7
`define I2CSP_REG_AW       7
`define I2CSP_REG_DEPTH    128
`define I2CSP_VERIFY_RESET 1'h0
`endif

// ### rtl/i2csp_pkg.sv
// Types shared by the two-wire register port
// Assumes the constants header sits beside it
`include "i2csp_consts.svh"
package i2csp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_IGNORE
  } i2csp_state_e;

  // Sampled bus events, one clock wide, and the synchronised SDA level
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } i2csp_bus_s;

  // Register file write request
  typedef struct packed {
    logic                       en;
    logic [`I2CSP_REG_AW-1:0]   addr;
    logic [`I2CSP_REG_AW-1:0]   data;
  } i2csp_wr_s;
endpackage

// ### rtl/i2csp_regmem.sv
// Register store behind the serial port, 7 bits per register
// Assumes one system clock; read data come out of a register
`include "i2csp_consts.svh"
module i2csp_regmem
  import i2csp_pkg::*;
#(
  parameter int AW    = `I2CSP_REG_AW,
  parameter int DEPTH = `I2CSP_REG_DEPTH
)
(
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [AW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [AW-1:0] rd_data
);
  logic [AW-1:0] mem [DEPTH];

  always_ff @(posedge CLK_SYS)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ### rtl/i2csp_port.sv
// Two-wire serial slave port giving access to the register store
// Assumes SCL/SDA arrive asynchronously and are oversampled at 40 MHz
`include "i2csp_consts.svh"
module i2csp_port
  import i2csp_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       ADDRESS_SELECT_PIN,
  input  wire logic       PROG_OK,
  input  wire logic       PROG_DONE,
  output logic            PROG_WRITE,
  output logic [7:0]      REGISTER_SELECT_POINTER
);
  logic [1:0]     scl_sync;
  logic [1:0]     sda_sync;
  logic           scl_q;
  logic           sda_q;
  i2csp_bus_s     bus;
  i2csp_state_e   state;
  logic [2:0]     bit_cnt;
  logic [7:0]     shift;
  logic [7:0]     tx;
  logic           first_data;
  logic           verify;
  logic           verify_armed;
  logic [6:0]     rd_data;
  i2csp_wr_s      wr;
  logic           ptr_seen;
  logic [1:0]     addr_sel_sync;
  logic           addr_sel;

  // Bit count wraps after the last data bit
  function automatic logic last_bit(input logic [2:0] c);
    return c == `I2CSP_BIT_LAST;
  endfunction

  // Received address byte against our slave address
  function automatic logic addr_hit(input logic [7:0] s, input logic pin);
    return s[7:1] == {`I2CSP_ADDR_HI, pin};
  endfunction

  // Address pin is a board level; synchronise it like the bus lines
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      addr_sel_sync <= 2'h0;
    end
    else
    begin
      addr_sel_sync <= {addr_sel_sync[0], ADDRESS_SELECT_PIN};
    end
  end

  assign addr_sel = addr_sel_sync[1];

  // Two-stage synchronisers; only the second stage is read onward
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'h1;
      sda_q    <= 1'h1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], SCL_IN};
      sda_sync <= {sda_sync[0], SDA_IN};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  always_comb
  begin
    bus.sda      = sda_sync[1];
    bus.scl_rise = scl_sync[1] & ~scl_q;
    bus.scl_fall = ~scl_sync[1] & scl_q;
    bus.start    = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    bus.stop     = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  end

  // only SDA has a driver; SCL is input only
  assign SDA_OUT = 1'h0;

  // Main byte sequencer
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= `I2CSP_BIT_FIRST;
      shift      <= 8'h00;
      first_data <= 1'h0;
    end
    else if (bus.start)
    begin
      state      <= ST_ADDR;
      bit_cnt    <= `I2CSP_BIT_FIRST;
      first_data <= 1'h1;
    end
    else if (bus.stop)
    begin
      state <= ST_IDLE;
    end
    else if (bus.scl_rise)
    begin
      case (state)
        ST_ADDR, ST_WR_BYTE:
        begin
          shift   <= {shift[6:0], bus.sda};
          bit_cnt <= bit_cnt + 3'h1;
        end
        ST_RD_BYTE:
        begin
          bit_cnt <= bit_cnt + 3'h1;
        end
        ST_RD_ACK:
        begin
          // NACK ends the read; ACK is not honoured
          state <= ST_IGNORE;
        end
        default:
        begin
        end
      endcase
    end
    else if (bus.scl_fall)
    begin
      case (state)
        ST_ADDR:
        begin
          if (bit_cnt == `I2CSP_BIT_FIRST && first_data)
          begin
            first_data <= 1'h0;
          end
          else if (bit_cnt == `I2CSP_BIT_FIRST)
          begin
            if (addr_hit(shift, addr_sel))
            begin
              state      <= ST_ADDR_ACK;
              first_data <= 1'h1;
            end
            else
            begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          state   <= shift[0] ? ST_RD_BYTE : ST_WR_BYTE;
          bit_cnt <= `I2CSP_BIT_FIRST;
        end
        ST_WR_BYTE:
        begin
          if (bit_cnt == `I2CSP_BIT_FIRST && !first_data)
          begin
            state <= ST_WR_ACK;
          end
          first_data <= 1'h0;
        end
        ST_WR_ACK:
        begin
          // bytes past the second are not acknowledged
          state   <= ptr_seen ? ST_IGNORE : ST_WR_BYTE;
          bit_cnt <= `I2CSP_BIT_FIRST;
        end
        ST_RD_BYTE:
        begin
          if (bit_cnt == `I2CSP_BIT_FIRST && !first_data)
          begin
            state <= ST_RD_ACK;
          end
          first_data <= 1'h0;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Pointer and write of the addressed register
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      REGISTER_SELECT_POINTER <= `I2CSP_PTR_RESET;
      wr                      <= '0;
      PROG_WRITE              <= 1'h0;
    end
    else
    begin
      PROG_WRITE <= 1'h0;
      wr.addr    <= REGISTER_SELECT_POINTER[6:0];
      if (bus.start)
      begin
        wr.en <= 1'h0;
      end
      else if (bus.scl_fall && state == ST_WR_BYTE
               && bit_cnt == `I2CSP_BIT_FIRST && !first_data)
      begin
        if (!ptr_seen)
        begin
          REGISTER_SELECT_POINTER <= shift;
        end
        else
        begin
          wr.en      <= 1'h1;
          wr.data    <= shift[6:0];
          PROG_WRITE <= REGISTER_SELECT_POINTER[`I2CSP_PROG_BIT];
        end
      end
      else
      begin
        wr.en <= 1'h0;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST || bus.start)
    begin
      ptr_seen <= 1'h0;
    end
    else if (bus.scl_fall && state == ST_WR_ACK)
    begin
      ptr_seen <= 1'h1;
    end
  end

  i2csp_regmem u_mem (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .wr_en   (wr.en),
    .wr_addr (wr.addr),
    .wr_data (wr.data),
    .rd_addr (REGISTER_SELECT_POINTER[6:0]),
    .rd_data (rd_data)
  );

  // verify flag held until the next read or write after programming
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      verify       <= `I2CSP_VERIFY_RESET;
      verify_armed <= 1'h0;
    end
    else if (PROG_DONE)
    begin
      verify       <= PROG_OK;
      verify_armed <= 1'h1;
    end
    else if (bus.scl_fall && state == ST_ADDR_ACK)
    begin
      verify_armed <= 1'h0;
      verify       <= verify_armed & shift[0] & verify;
    end
  end

  // Transmit shift: loaded as the read byte begins
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      tx <= 8'h00;
    end
    else if (bus.scl_fall && state == ST_ADDR_ACK)
    begin
      // flag on bit 7, data below
      tx <= {verify_armed & verify, rd_data};
    end
    else if (bus.scl_fall && state == ST_RD_BYTE)
    begin
      // Shift on every fall so tx[6] is always the next bit out
      tx <= {tx[6:0], 1'h0};
    end
  end

  // Open-drain: enable pulls SDA low
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      SDA_OE <= 1'h0;
    end
    else if (bus.start || bus.stop)
    begin
      SDA_OE <= 1'h0;
    end
    else if (bus.scl_fall)
    begin
      case (state)
        // ack the first two write bytes; ack on match
        ST_ADDR:
          SDA_OE <= bit_cnt == `I2CSP_BIT_FIRST && !first_data
                    && addr_hit(shift, addr_sel);
        // Third byte never gets here: WR_ACK sends it to ST_IGNORE
        ST_WR_BYTE:
          SDA_OE <= bit_cnt == `I2CSP_BIT_FIRST && !first_data;
        // drive data MSB first then release
        ST_ADDR_ACK:
          SDA_OE <= shift[0] ? ~(verify_armed & verify) : 1'h0;
        ST_RD_BYTE:
          SDA_OE <= (bit_cnt == `I2CSP_BIT_FIRST && !first_data)
                    ? 1'h0 : ~tx[6];
        default:
          SDA_OE <= 1'h0;
      endcase
    end
  end

  // acknowledge only changes after SCL falls
  property p_ack_stable;
    @(posedge CLK_SYS) disable iff (RST)
      (scl_sync[1] && scl_q) |->
        $stable(SDA_OE) || $past(bus.start) || $past(bus.stop);
  endproperty
  a_ack_stable: assert property (p_ack_stable)
    else $error("SDA drive changed while SCL high");

  property p_no_ack_idle;
    @(posedge CLK_SYS) disable iff (RST)
      state == ST_IDLE |-> ##1 !SDA_OE || !bus.scl_fall;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle)
    else $error("SDA driven while idle");

  property p_sda_out_low;
    @(posedge CLK_SYS) disable iff (RST)
      SDA_OUT == 1'h0;
  endproperty
  a_sda_out_low: assert property (p_sda_out_low)
    else $error("SDA output level not low");

  // End of the address byte, split by the compare result
  sequence s_addr_match;
    bus.scl_fall && state == ST_ADDR && bit_cnt == `I2CSP_BIT_FIRST
      && !first_data && addr_hit(shift, addr_sel);
  endsequence

  sequence s_addr_miss;
    bus.scl_fall && state == ST_ADDR && bit_cnt == `I2CSP_BIT_FIRST
      && !first_data && !addr_hit(shift, addr_sel);
  endsequence

  property p_match_ack;
    @(posedge CLK_SYS) disable iff (RST)
      s_addr_match |=> SDA_OE && state == ST_ADDR_ACK;
  endproperty
  a_match_ack: assert property (p_match_ack)
    else $error("Matching address not acknowledged");

  property p_miss_nack;
    @(posedge CLK_SYS) disable iff (RST)
      s_addr_miss |=> !SDA_OE && state == ST_IGNORE;
  endproperty
  a_miss_nack: assert property (p_miss_nack)
    else $error("Foreign address acknowledged");

  property p_ignore_quiet;
    @(posedge CLK_SYS) disable iff (RST)
      state == ST_IGNORE |-> !SDA_OE;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet)
    else $error("SDA driven in ignored transfer");

  property p_write_pulse;
    @(posedge CLK_SYS) disable iff (RST)
      wr.en |=> !wr.en;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("Register write longer than one clock");
endmodule

// ### verif/i2csp_master_model.sv
// Behavioural two-wire bus master driving the register port
// Assumes the bench resolves SDA from both open-drain parties
module i2csp_master_model
(
  input  wire logic CLK_SYS,
  input  wire logic SDA,
  output logic      SCL,
  output logic      SDA_LOW
);
  timeunit 1ns;
  timeprecision 100ps;
  // Phases kept above the port's eight-clock minimum
  localparam int HP = 10;
  initial
  begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic start();
    SDA_LOW = 1'b1;
    hold(HP);
    SCL = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    hold(3);
    SDA_LOW = ~b;
    hold(HP);
    SCL = 1'b1;
    hold(HP);
    r = SDA;
    SCL = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic stop();
    hold(3);
    SDA_LOW = 1'b1;
    hold(HP);
    SCL = 1'b1;
    hold(HP);
    SDA_LOW = 1'b0;
    hold(HP);
  endtask
  task automatic wr(input logic [31:0] d, input int n,
                    output logic [3:0] ak);
    logic [7:0] q;
    ak = 4'h0;
    start();
    for (int i = 0; i < n; i++)
      byte_io(d[31-8*i -: 8], q, ak[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] ab, output logic ack,
                    output logic [7:0] q);
    logic [7:0] z;
    start();
    byte_io(ab, z, ack);
    byte_io(8'hFF, q, z[0]);
    stop();
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the two-wire register port
// Assumes the master model file and the design are compiled first
module tb;
  import i2csp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLK_SYS;
  logic       RST;
  logic       ADDRESS_SELECT_PIN;
  logic       PROG_OK;
  logic       PROG_DONE;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic       sda;
  logic       prog_write;
  logic [7:0] ptr;
  logic [3:0] ak;
  logic       ack;
  logic [7:0] q;
  int         bad_count;
  int         num_checks;
  int         prog_seen;
  // Pull-up wins unless a party pulls low
  assign sda = ~(sda_oe | sda_low);
  initial CLK_SYS = 1'b0;
  always #12.5 CLK_SYS = ~CLK_SYS;
  i2csp_port uut (.CLK_SYS(CLK_SYS), .RST(RST), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN), .PROG_OK(PROG_OK),
    .PROG_DONE(PROG_DONE), .PROG_WRITE(prog_write),
    .REGISTER_SELECT_POINTER(ptr));
  i2csp_master_model m (.CLK_SYS(CLK_SYS), .SDA(sda), .SCL(scl),
    .SDA_LOW(sda_low));
  always @(posedge CLK_SYS)
    if (prog_write === 1'b1)
      prog_seen++;
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] p, d);
    m.wr({8'h5C, p, d, 8'h00}, 3, ak);
    chk("wr_ack", {4'h0, ak}, 8'h07);
    chk("wr_ptr", ptr, p);
  endtask
  task automatic setp(input logic [7:0] p);
    m.wr({8'h5C, p, 16'h0000}, 2, ak);
    chk("ptr_ack", {4'h0, ak}, 8'h03);
  endtask
  task automatic rreg(input logic [7:0] exp);
    m.rd(8'h5D, ack, q);
    chk("rd_ack", {7'h0, ack}, 8'h01);
    chk("rd_data", q, exp);
  endtask
  initial
  begin
    RST = 1'b1;
    ADDRESS_SELECT_PIN = 1'b0;
    PROG_OK = 1'b0;
    PROG_DONE = 1'b0;
    repeat (6) @(posedge CLK_SYS);
    #1 RST = 1'b0;
    m.hold(5);
    chk("ptr_rst", ptr, 8'h00);
    chk("sda_out", {7'h0, sda_out}, 8'h00);
    wreg(8'h05, 8'h5A);
    wreg(8'h7F, 8'h7F);
    wreg(8'h10, 8'h33);
    setp(8'h05);
    chk("ptr_only", ptr, 8'h05);
    rreg(8'h5A);
    rreg(8'h5A);
    setp(8'h10);
    rreg(8'h33);
    setp(8'h7F);
    rreg(8'h7F);
    m.wr({8'h5C, 8'h10, 8'h44, 8'h55}, 4, ak);
    chk("third", {4'h0, ak}, 8'h07);
    rreg(8'h44);
    for (int p = 0; p < 2; p++)
    begin
      ADDRESS_SELECT_PIN = p[0];
      for (int a = 0; a < 2; a++)
      begin
        m.wr({6'h17, a[0], 1'b0, 8'h05, 16'h0000}, 2, ak);
        chk("match", {4'h0, ak}, (a == p) ? 8'h03 : 8'h00);
      end
    end
    ADDRESS_SELECT_PIN = 1'b0;
    chk("no_prog", prog_seen[7:0], 8'h00);
    m.wr({8'h5C, 8'h81, 8'h0F, 8'h00}, 3, ak);
    chk("prog_wr", prog_seen[7:0], 8'h01);
    PROG_OK = 1'b1;
    PROG_DONE = 1'b1;
    m.hold(1);
    PROG_DONE = 1'b0;
    m.rd(8'h5D, ack, q);
    chk("vfy_on", {7'h0, q[7]}, 8'h01);
    m.rd(8'h5D, ack, q);
    chk("vfy_off", {7'h0, q[7]}, 8'h00);
    print_verdict();
  end
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    prog_seen = 0;
    repeat (60000) @(posedge CLK_SYS);
    bad_count++;
    print_verdict();
  end
endmodule
